// ===== hw/ple_top.sv
// Programmable logic equation bank with AHB-Lite configuration and readback
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ple_top
	import ple_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic [EXT_W-1:0]  pool_in,
	output logic      [NUM_EQ-1:0] eq_plain,
	output logic      [NUM_EQ-1:0] eq_latched,
	output logic      [NUM_EQ-1:0] eq_latched_n
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ple_rd_t                  rd;
	ple_wr_t                  wr;
	logic [63:0]              eng_rdata;
	logic [63:0]              bus_rdata;
	ple_cfg_t                 cfg;
	ple_state_t               state_q;
	logic [IDX_W-1:0]         idx_q;
	logic [TICK_W-1:0]        tick_cnt_q;
	logic                     tick;
	logic                     run_q;
	logic [EXT_W-1:0]         pool_s1_q;
	logic [EXT_W-1:0]         pool_s2_q;
	logic [NUM_EQ-1:0]        plain_q;
	logic [NUM_EQ-1:0]        latch_q;
	logic [DLY_W-1:0]         cnt_q [NUM_EQ];
	logic [NUM_EQ*NUM_IN-1:0] eqin_q;
	logic [NUM_IN-1:0]        cin;
	logic [NUM_IN-1:0]        cuse;
	logic                     gate_res;
	logic [DLY_W-1:0]         cur_dly;
	logic                     differ;
	logic                     fire;
	logic                     d_new;
	logic                     rst_act;
	logic                     latch_new;
	logic                     is_cfg_wr;
	logic                     cfg_rd_q;
	logic                     half_q;
	logic [31:0]              rdata_q;

	// Pool lookup: external inputs, then plain, then latched outputs
	function automatic logic pool_bit(
		input logic [SEL_W-1:0]  sel,
		input logic [EXT_W-1:0]  ext,
		input logic [NUM_EQ-1:0] plain,
		input logic [NUM_EQ-1:0] latched
	);
		logic b;
		if (sel < POOL_PLAIN_BASE)
			b = ext[sel[3:0]];
		else if (sel < POOL_LATCH_BASE)
			b = plain[sel[2:0]];
		else
			b = latched[sel[2:0]];
		return b;
	endfunction

	// ----------------------------------------
	// Bus front end and configuration store
	// ----------------------------------------
	ple_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rd        (rd),
		.wr        (wr)
	);

	assign is_cfg_wr = wr.en && wr.addr[11:6] == CFG_REGION;

	ple_cfg_mem u_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wr_lo   (is_cfg_wr && !wr.addr[2]),
		.wr_hi   (is_cfg_wr && wr.addr[2]),
		.waddr   (wr.addr[5:3]),
		.wdata   (wr.data),
		.ra_addr (idx_q),
		.ra_data (eng_rdata),
		.rb_en   (rd.en),
		.rb_addr (rd.addr[5:3]),
		.rb_data (bus_rdata)
	);

	// ----------------------------------------
	// Input synchroniser and process tick
	// ----------------------------------------
	// Pool inputs come from other logic timing, so two stages first
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pool_s1_q <= '0;
			pool_s2_q <= '0;
		end
		else
		begin
			pool_s1_q <= pool_in;
			pool_s2_q <= pool_s1_q;
		end
	end

	// Divider gives one tick per process cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 16'h0001;
	end

	assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1));

	// Run enable from software
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			run_q <= CTRL_RUN_RESET;
		else if (wr.en && wr.addr == OFS_CTRL)
			run_q <= wr.data[CTRL_RUN_BIT];
	end

	// ----------------------------------------
	// Evaluation sequencer
	// ----------------------------------------
	// A tick during a running pass is dropped; the pass is far shorter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= ST_IDLE;
			idx_q   <= '0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (tick && run_q)
					begin
						state_q <= ST_FETCH;
						idx_q   <= '0;
					end
				end
				ST_FETCH:
					state_q <= ST_EVAL;
				ST_EVAL:
				begin
					if (idx_q == LAST_IDX)
						state_q <= ST_IDLE;
					else
					begin
						state_q <= ST_FETCH;
						idx_q   <= idx_q + 3'h1;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Equation datapath
	// ----------------------------------------
	assign cfg = ple_cfg_t'(eng_rdata);

	// Live output vectors: earlier equations already hold this pass's value
	genvar k;
	generate
		for (k = 0; k < NUM_IN; k++)
		begin : g_in
			assign cin[k]  = pool_bit(cfg.sel[k], pool_s2_q, plain_q, latch_q) ^ cfg.inv[k];
			assign cuse[k] = cin[k] | ~cfg.used[k];
		end
	endgenerate

	// Unused inputs are neutral; an equation with none stays low
	always_comb
	begin
		case (cfg.gate)
			GATE_AND:  gate_res = &cuse;
			GATE_OR:   gate_res = |(cin & cfg.used);
			GATE_NAND: gate_res = ~&cuse;
			GATE_NOR:  gate_res = ~|(cin & cfg.used);
			GATE_XOR:  gate_res = ^(cin & cfg.used);
			GATE_XNOR: gate_res = ~^(cin & cfg.used);
			default:   gate_res = 1'b0;
		endcase
		if (cfg.used == 4'h0)
			gate_res = 1'b0;
	end

	// Timer: count passes while the gate disagrees with the output
	assign cur_dly   = gate_res ? cfg.rise : cfg.fall;
	assign differ    = gate_res != plain_q[idx_q];
	assign fire      = differ && cnt_q[idx_q] >= cur_dly;
	assign d_new     = fire ? gate_res : plain_q[idx_q];
	assign rst_act   = cfg.rst_used && (pool_bit(cfg.rst_sel, pool_s2_q, plain_q, latch_q) ^ cfg.rst_inv);
	assign latch_new = !rst_act && (d_new || latch_q[idx_q]);

	// Output and latch state, written only for the equation in hand
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			plain_q <= '0;
			latch_q <= '0;
		end
		else if (state_q == ST_EVAL)
		begin
			plain_q[idx_q] <= d_new;
			latch_q[idx_q] <= latch_new;
		end
	end

	// Per-equation delay counters in whole passes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NUM_EQ; i++)
				cnt_q[i] <= '0;
		end
		else if (state_q == ST_EVAL)
			cnt_q[idx_q] <= (differ && !fire) ? cnt_q[idx_q] + 8'h01 : 8'h00;
	end

	// Conditioned inputs kept for status readback
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			eqin_q <= '0;
		else if (state_q == ST_EVAL)
			eqin_q[idx_q*NUM_IN +: NUM_IN] <= cin;
	end

	assign eq_plain     = plain_q;
	assign eq_latched   = latch_q;
	assign eq_latched_n = ~latch_q;

	// ----------------------------------------
	// Register readback
	// ----------------------------------------
	// Captured in the address phase so hrdata stands through the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rdata_q  <= 32'h0;
			cfg_rd_q <= 1'b0;
			half_q   <= 1'b0;
		end
		else if (rd.en)
		begin
			cfg_rd_q <= rd.addr[11:6] == CFG_REGION;
			half_q   <= rd.addr[2];
			case (rd.addr)
				OFS_CTRL:   rdata_q <= {31'h0, run_q};
				OFS_STATUS: rdata_q <= {15'h0, state_q != ST_IDLE, latch_q, plain_q};
				OFS_INPUTS: rdata_q <= {16'h0, pool_s2_q};
				OFS_EQIN:   rdata_q <= eqin_q;
				default:    rdata_q <= 32'h0;
			endcase
		end
	end

	assign hrdata = cfg_rd_q ? (half_q ? bus_rdata[63:32] : bus_rdata[31:0]) : rdata_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_reset_wins;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_EVAL && rst_act) |=> !latch_q[$past(idx_q)];
	endproperty
	a_reset_wins: assert property (p_reset_wins) else $error("latch not cleared by reset");

	property p_latch_sets;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_EVAL && !rst_act && d_new) |=> latch_q[$past(idx_q)] && !eq_latched_n[$past(idx_q)];
	endproperty
	a_latch_sets: assert property (p_latch_sets) else $error("latch did not set");

	property p_latch_holds;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_EVAL && !rst_act && latch_q[idx_q]) |=> latch_q[$past(idx_q)];
	endproperty
	a_latch_holds: assert property (p_latch_holds) else $error("latch dropped without reset");

	property p_pass_start;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_IDLE && tick && run_q) |=> (state_q == ST_FETCH && idx_q == 3'h0);
	endproperty
	a_pass_start: assert property (p_pass_start) else $error("pass did not start at first equation");

	property p_pass_len;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_FETCH && idx_q == 3'h0) |-> ##15 (state_q == ST_EVAL && idx_q == LAST_IDX) ##1 (state_q == ST_IDLE);
	endproperty
	a_pass_len: assert property (p_pass_len) else $error("pass length wrong");

	property p_ascend;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_EVAL && idx_q != LAST_IDX) |=> ##1 (idx_q == $past(idx_q, 2) + 3'h1);
	endproperty
	a_ascend: assert property (p_ascend) else $error("equations not in ascending order");

	property p_no_delay;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_EVAL && cur_dly == 8'h00) |=> plain_q[$past(idx_q)] == $past(gate_res);
	endproperty
	a_no_delay: assert property (p_no_delay) else $error("zero delay output not following gate");

	property p_delay_hold;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_EVAL && differ && cnt_q[idx_q] < cur_dly) |=> $stable(plain_q);
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("output changed before delay ran out");

	property p_out_only_eval;
		@(posedge hclk) disable iff (!hresetn)
		!$stable(plain_q) |-> $past(state_q) == ST_EVAL;
	endproperty
	a_out_only_eval: assert property (p_out_only_eval) else $error("output changed outside evaluation");

endmodule // ple_top
`default_nettype wire

// ===== hw/ple_pkg.sv
// Shared constants, types and register map of the logic equation bank
package ple_pkg;

	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int NUM_EQ        = 8;
	localparam int EXT_W         = 16;
	localparam int SEL_W         = 5;
	localparam int DLY_W         = 8;
	localparam int IDX_W         = 3;
	localparam int NUM_IN        = 4;
	localparam int CLK_HZ        = 10_000_000;
	localparam int PROC_CYCLE_US = 1000;
	localparam int TICK_CYCLES   = PROC_CYCLE_US * (CLK_HZ / 1_000_000);
	localparam int TICK_W        = 16;

	// ----------------------------------------
	// Signal pool layout
	// ----------------------------------------
	localparam logic [SEL_W-1:0] POOL_PLAIN_BASE = 5'h10;
	localparam logic [SEL_W-1:0] POOL_LATCH_BASE = 5'h18;
	localparam logic [IDX_W-1:0] LAST_IDX        = 3'h7;

	// ----------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_INPUTS = 12'h008;
	localparam logic [11:0] OFS_EQIN   = 12'h00C;
	localparam logic [5:0]  CFG_REGION = 6'h04;
	localparam int          CTRL_RUN_BIT    = 0;
	localparam logic        CTRL_RUN_RESET  = 1'b1;
	localparam int          STATUS_BUSY_BIT = 16;
	localparam logic [31:0] CFG_LO_MASK = 32'h7FFFFFFF;
	localparam logic [31:0] CFG_HI_MASK = 32'h007FFFFF;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		GATE_AND  = 3'b000,
		GATE_OR   = 3'b001,
		GATE_NAND = 3'b010,
		GATE_NOR  = 3'b011,
		GATE_XOR  = 3'b100,
		GATE_XNOR = 3'b101
	} ple_gate_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_EVAL  = 2'b10
	} ple_state_t;

	typedef struct packed {
		logic [8:0]                   pad_hi;
		logic [DLY_W-1:0]             fall;
		logic [DLY_W-1:0]             rise;
		logic                         rst_used;
		logic                         rst_inv;
		logic [SEL_W-1:0]             rst_sel;
		logic                         pad_lo;
		ple_gate_t                    gate;
		logic [NUM_IN-1:0]            used;
		logic [NUM_IN-1:0]            inv;
		logic [NUM_IN-1:0][SEL_W-1:0] sel;
	} ple_cfg_t;

	typedef struct packed {
		logic        en;
		logic [11:0] addr;
		logic [31:0] data;
	} ple_wr_t;

	typedef struct packed {
		logic        en;
		logic [11:0] addr;
	} ple_rd_t;

endpackage

// ===== hw/ple_cfg_mem.sv
// Equation configuration memory: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module ple_cfg_mem
	import ple_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             wr_lo,
	input  wire logic             wr_hi,
	input  wire logic [IDX_W-1:0] waddr,
	input  wire logic [31:0]      wdata,
	input  wire logic [IDX_W-1:0] ra_addr,
	output logic      [63:0]      ra_data,
	input  wire logic             rb_en,
	input  wire logic [IDX_W-1:0] rb_addr,
	output logic      [63:0]      rb_data
);

	logic [63:0] mem_q [NUM_EQ];
	logic [63:0] merged;

	// Entry value after this cycle's write, used for forwarding
	always_comb
	begin
		merged = mem_q[waddr];
		if (wr_lo)
			merged[31:0] = wdata & CFG_LO_MASK;
		if (wr_hi)
			merged[63:32] = wdata & CFG_HI_MASK;
	end

	// Storage; cleared so equations stay inert until programmed
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NUM_EQ; i++)
				mem_q[i] <= 64'h0;
		end
		else if (wr_lo || wr_hi)
			mem_q[waddr] <= merged;
	end

	// Engine port; a write lands before the entry's next fetch anyway
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ra_data <= 64'h0;
		else
			ra_data <= mem_q[ra_addr];
	end

	// Bus port forwards a same-cycle write so readback is never stale
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rb_data <= 64'h0;
		else if (rb_en)
			rb_data <= ((wr_lo || wr_hi) && waddr == rb_addr) ? merged : mem_q[rb_addr];
	end

endmodule // ple_cfg_mem
`default_nettype wire

// ===== hw/ple_ahb_slave.sv
// AHB-Lite slave front end: zero wait states, always OKAY
`timescale 1ns/1ps
`default_nettype none
module ple_ahb_slave
	import ple_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output ple_rd_t          rd,
	output ple_wr_t          wr
);

	logic        take;
	logic        wr_pend_q;
	logic [11:0] wr_addr_q;

	// Only aligned word transfers are served; others are ignored and hrdata keeps its last value
	assign take      = hsel && hready && htrans[1] && hsize == 3'b010 && haddr[1:0] == 2'b00;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign rd.en     = take && !hwrite;
	assign rd.addr   = haddr[11:0];

	// Write address is held over into the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end
		else if (hready)
		begin
			wr_pend_q <= take && hwrite;
			wr_addr_q <= haddr[11:0];
		end
	end

	assign wr.en   = wr_pend_q;
	assign wr.addr = wr_addr_q;
	assign wr.data = hwdata;

endmodule // ple_ahb_slave
`default_nettype wire

// ===== sim/ple_pool_model.sv
// Far-side model: the relay's signal pool feeding the equation bank
`timescale 1ns/1ps
`default_nettype none
module ple_pool_model
	import ple_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [EXT_W-1:0] drive_val,
	output logic      [EXT_W-1:0] pool_in
);
	// ----------------------------------------
	// Pool levels
	// ----------------------------------------
	// Levels move only after an edge, so the 2-flop sync never sees a race
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pool_in <= '0;
		else
			pool_in <= drive_val;
	end
endmodule // ple_pool_model
`default_nettype wire

// ===== sim/test_programmable_logic_equations.sv
// Self-checking testbench of the logic equation bank
`timescale 1ns/1ps
`default_nettype none
module test_programmable_logic_equations;
	import ple_pkg::*;
	localparam int T = 32;
	logic              hclk;
	logic              hresetn;
	logic              hsel;
	logic [31:0]       haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [31:0]       hwdata;
	logic [31:0]       hrdata;
	logic              hready;
	logic              hresp;
	logic [EXT_W-1:0]  pool_drv;
	logic [EXT_W-1:0]  pool_in;
	logic [NUM_EQ-1:0] eq_plain;
	logic [NUM_EQ-1:0] eq_latched;
	logic [NUM_EQ-1:0] eq_latched_n;
	int                err_total;
	int                checked;

	// ----------------------------------------
	// Design and pool model
	// ----------------------------------------
	ple_top #(.TICK_CYCLES_P(T)) ple_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .pool_in(pool_in), .eq_plain(eq_plain),
		.eq_latched(eq_latched), .eq_latched_n(eq_latched_n));
	ple_pool_model ple_pool_model_inst (.hclk(hclk), .hresetn(hresetn), .drive_val(pool_drv), .pool_in(pool_in));

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// About eighteen times the expected run length
	initial
	begin
		#3000000;
		err_total = err_total + 1;
		final_report();
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked = checked + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	// One single word transfer; address held until hready, then data phase
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {20'h00000, a};
		hsize  <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr32(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] x;
		ahb(1'b0, a, 32'h00000000, x);
		chk(x, exp, msg);
	endtask
	// One-input OR equation on pool entry s, used by the cascade, delay and latch scenarios
	task automatic cfg(input int i, input logic [31:0] lo, input logic [31:0] hi);
		wr32(12'h100 + 12'(8 * i), lo);
		wr32(12'h104 + 12'(8 * i), hi);
	endtask
	function automatic logic [31:0] or1(input logic [4:0] s);
		return {1'b0, 3'h1, 4'h1, 4'h0, 15'h0000, s};
	endfunction
	task automatic drive(input int b, input logic v);
		@(posedge hclk);
		pool_drv[b] <= v;
	endtask
	task automatic final_report();
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(32'(eq_latched_n), 32'h000000FF, "latched_n reset");
		rd_chk(OFS_CTRL, 32'h00000001, "ctrl reset");
		rd_chk(OFS_STATUS, 32'h00000000, "status reset");
	endtask
	// Inputs a=1, b=0 through every gate, then b inverted
	task automatic t_gates();
		logic [5:0] exp;
		exp = 6'b010110;
		pool_drv[1:0] <= 2'b01;
		for (int g = 0; g < 6; g++)
		begin
			cfg(0, {1'b0, 3'(g), 4'h3, 4'h0, 10'h000, 5'h01, 5'h00}, 32'h00000000);
			repeat (3 * T) @(posedge hclk);
			chk(32'(eq_plain[0]), 32'(exp[g]), "gate out");
		end
		cfg(0, {1'b0, 3'h0, 4'h3, 4'h2, 10'h000, 5'h01, 5'h00}, 32'h00000000);
		repeat (3 * T) @(posedge hclk);
		chk(32'(eq_plain[0]), 32'h1, "inverted input");
		rd_chk(OFS_EQIN, 32'hFFFFFFFF, "eqin conditioned");
	endtask
	// Equation 2 feeds equation 3 forward and equation 1 backward
	task automatic t_cascade();
		int n;
		cfg(2, or1(5'h02), 32'h0);
		cfg(1, or1(5'h12), 32'h0);
		cfg(3, or1(5'h12), 32'h0);
		repeat (3 * T) @(posedge hclk);
		drive(2, 1'b1);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (eq_plain[2] !== 1'b1 && n < 200);
		repeat (4) @(posedge hclk);
		chk(32'(eq_plain[3]), 32'h1, "forward same pass");
		chk(32'(eq_plain[1]), 32'h0, "backward not yet");
		repeat (T + 8) @(posedge hclk);
		chk(32'(eq_plain[1]), 32'h1, "backward next pass");
	endtask
	// Rise delay of two passes, fall delay of zero
	task automatic t_delay();
		int n;
		cfg(4, or1(5'h04), 32'h00000100);
		repeat (3 * T) @(posedge hclk);
		drive(4, 1'b1);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (eq_plain[4] !== 1'b1 && n < 400);
		chk(32'(n >= 2 * T && n <= 3 * T + 24), 32'h1, "rise delay");
		drive(4, 1'b0);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (eq_plain[4] !== 1'b0 && n < 400);
		chk(32'(n <= T + 24), 32'h1, "fall delay");
	endtask
	// Latch set by pool 5, cleared by pool 6
	task automatic t_latch();
		cfg(5, or1(5'h05), 32'h00000046);
		drive(5, 1'b1);
		repeat (3 * T) @(posedge hclk);
		drive(5, 1'b0);
		repeat (3 * T) @(posedge hclk);
		chk(32'({eq_plain[5], eq_latched[5], eq_latched_n[5]}), 32'h2, "latch holds");
		drive(5, 1'b1);
		drive(6, 1'b1);
		repeat (3 * T) @(posedge hclk);
		chk(32'(eq_latched[5]), 32'h0, "reset wins");
		drive(6, 1'b0);
		repeat (3 * T) @(posedge hclk);
		chk(32'(eq_latched[5]), 32'h1, "set after reset");
		wr32(12'h12C, 32'h00000066);
		repeat (3 * T) @(posedge hclk);
		chk(32'(eq_latched[5]), 32'h0, "inverted reset");
	endtask
	// Passes are stopped first so the busy flag reads a known value
	task automatic t_readback();
		wr32(OFS_CTRL, 32'h00000000);
		repeat (20) @(posedge hclk);
		rd_chk(OFS_CTRL, 32'h00000000, "run off");
		rd_chk(OFS_INPUTS, 32'h00000025, "inputs");
		rd_chk(OFS_STATUS, 32'h00001F2F, "status");
		chk(32'(hresp), 32'h0, "okay response");
		rd_chk(12'h104, 32'h00000000, "cfg hi");
		rd_chk(12'h120, 32'h11000004, "cfg lo");
		rd_chk(12'h800, 32'h00000000, "unmapped");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		err_total = 0;
		checked   = 0;
		hresetn   = 1'b0;
		hsel      = 1'b0;
		haddr     = 32'h00000000;
		htrans    = 2'h0;
		hwrite    = 1'b0;
		hsize     = 3'h2;
		hwdata    = 32'h00000000;
		pool_drv  = 16'h0000;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_gates();
		t_cascade();
		t_delay();
		t_latch();
		t_readback();
		final_report();
	end
endmodule // test_programmable_logic_equations
`default_nettype wire
